/* acs_command_status.sv */
`timescale 1ns/1ps
module acs_command_status
  import acs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic [5:0]       reg_sel,
  output logic             reg_wr_strobe,
  output logic [23:0]      reg_wr_data,
  input  wire logic [23:0] reg_rd_data,
  output logic             filter_restart,
  input  wire logic        result_valid,
  input  wire logic [23:0] result_data,
  input  wire logic [1:0]  result_chan,
  input  wire logic        result_over,
  input  wire logic        result_under,
  input  wire logic        cal_done,
  input  wire logic        wr_crc_mismatch,
  input  wire logic        append_status_en,
  input  wire logic        integ_check_en,
  input  wire logic [23:0] cfg_signature,
  output logic [7:0]       status_byte,
  output logic [23:0]      data_word
);

  // ==========================================================
  // Selector decode
  function automatic logic [5:0] acs_sel_bits(input logic [5:0] sel);
    logic [3:0] grp;
    grp = sel[5:2];
    // Zero length marks a selector the command stage refuses
    acs_sel_bits = ACS_BITS_NONE;
    case (sel)
      ACS_SEL_STATUS: acs_sel_bits = ACS_BITS_B1;
      ACS_SEL_MODE:   acs_sel_bits = ACS_BITS_B2;
      ACS_SEL_IFMODE: acs_sel_bits = ACS_BITS_B2;
      ACS_SEL_CSUM:   acs_sel_bits = ACS_BITS_B3;
      ACS_SEL_DATA:   acs_sel_bits = ACS_BITS_B3;
      ACS_SEL_GPIO:   acs_sel_bits = ACS_BITS_B2;
      ACS_SEL_ID:     acs_sel_bits = ACS_BITS_B2;
      default:        acs_sel_bits = ACS_BITS_NONE;
    endcase
    if (grp == ACS_GRP_CHAN || grp == ACS_GRP_SETUP)
      acs_sel_bits = ACS_BITS_B2;
    if (grp == ACS_GRP_FILT)
      acs_sel_bits = ACS_BITS_B2;
    if (grp == ACS_GRP_OFFS || grp == ACS_GRP_GAIN)
      acs_sel_bits = ACS_BITS_B3;
  endfunction

  typedef struct packed {
    // Two stages settle the pins, a third finds sclk edges
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_s3;
    logic        cs_s1;
    logic        cs_s2;
    logic        din_s1;
    logic        din_s2;
    acs_state_t  st;
    logic [5:0]  cnt;
    logic [5:0]  sel;
    logic [31:0] sh;
    logic        rdy_n;
    logic        range_f;
    logic        crc_f;
    logic        integ_f;
    logic [1:0]  chan;
    logic [23:0] data;
    logic [23:0] ref_sum;
    logic        integ_en_d;
    logic        wr_strobe;
    logic [23:0] wr_data;
    logic        mode_wr;
    logic        dout;
    logic        dout_oe;
  } acs_regs_t;

  // ==========================================================
  // Status byte packing, shared by read path and port
  function automatic logic [7:0] acs_pack_status(input acs_regs_t r);
    acs_pack_status = {r.rdy_n, r.range_f, r.crc_f, r.integ_f,
                       ACS_ST_RSVD, r.chan};
  endfunction

  acs_regs_t r_ff;
  acs_regs_t nxt_r;

  logic       sclk_rise;
  logic       sclk_fall;
  logic [7:0] stat;
  logic [7:0] cmd_byte;
  logic [5:0] nbits;

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_r = r_ff;
    // Strobes default low: one-cycle pulses
    nxt_r.wr_strobe = 1'b0;
    nxt_r.mode_wr   = 1'b0;

    // Link pins pass two flops before any use
    nxt_r.sclk_s1 = sclk;
    nxt_r.sclk_s2 = r_ff.sclk_s1;
    nxt_r.sclk_s3 = r_ff.sclk_s2;
    nxt_r.cs_s1   = cs_n;
    nxt_r.cs_s2   = r_ff.cs_s1;
    nxt_r.din_s1  = din;
    nxt_r.din_s2  = r_ff.din_s1;

    // Edges only from the settled stages
    sclk_rise = r_ff.sclk_s2 & ~r_ff.sclk_s3;
    sclk_fall = ~r_ff.sclk_s2 & r_ff.sclk_s3;
    stat = acs_pack_status(r_ff);
    cmd_byte = {r_ff.sh[6:0], r_ff.din_s2};
    nbits = acs_sel_bits(cmd_byte[5:0]);

    if (r_ff.st != ACS_RD)
      nxt_r.dout = r_ff.rdy_n;
    // Enable lags the synced select by a cycle
    nxt_r.dout_oe = ~r_ff.cs_s2;

    case (r_ff.st)
      ACS_CMD:
      begin
        if (sclk_rise)
        begin
          nxt_r.sh  = {r_ff.sh[30:0], r_ff.din_s2};
          nxt_r.cnt = r_ff.cnt - 6'h01;
          if (r_ff.cnt == 6'h01)
          begin
            nxt_r.cnt = ACS_BITS_CMD;
            nxt_r.sel = cmd_byte[5:0];
            // A refused byte still loads sel and restarts the count
            // enable bit must be low
            if (!cmd_byte[ACS_CMD_WEN_BIT] && nbits != ACS_BITS_NONE)
            begin
              if (cmd_byte[ACS_CMD_RD_BIT])
                nxt_r.st = ACS_LD;
              else
              begin
                nxt_r.st  = ACS_WR;
                nxt_r.cnt = nbits;
                // Cleared so short payloads land right aligned
                nxt_r.sh  = 32'h00000000;
              end
            end
          end
        end
      end
      ACS_WR:
      begin
        if (sclk_rise)
        begin
          nxt_r.sh  = {r_ff.sh[30:0], r_ff.din_s2};
          nxt_r.cnt = r_ff.cnt - 6'h01;
          if (r_ff.cnt == 6'h01)
          begin
            nxt_r.st  = ACS_CMD;
            nxt_r.cnt = ACS_BITS_CMD;
            if (r_ff.sel != ACS_SEL_STATUS)
            begin
              nxt_r.wr_strobe = 1'b1;
              nxt_r.wr_data   = {r_ff.sh[22:0], r_ff.din_s2};
            end
            if (r_ff.sel == ACS_SEL_MODE)
            begin
              nxt_r.mode_wr = 1'b1;
              nxt_r.rdy_n   = 1'b1;
            end
          end
        end
      end
      ACS_LD:
      begin
        // One cycle lets reg_sel settle before rd data is taken
        nxt_r.st  = ACS_RD;
        nxt_r.cnt = acs_sel_bits(r_ff.sel);
        case (acs_sel_bits(r_ff.sel))
          ACS_BITS_B3: nxt_r.sh = {reg_rd_data, 8'h00};
          default:     nxt_r.sh = {reg_rd_data[15:0], 16'h0000};
        endcase
        if (r_ff.sel == ACS_SEL_STATUS)
        begin
          nxt_r.sh    = {stat, 24'h000000};
          nxt_r.crc_f = 1'b0;
        end
        if (r_ff.sel == ACS_SEL_DATA)
        begin
          nxt_r.sh = {r_ff.data, 8'h00};
          if (append_status_en)
          begin
            nxt_r.sh  = {r_ff.data, stat};
            nxt_r.cnt = ACS_BITS_B3 + ACS_BITS_B1;
          end
          // Raised at load: a result mid-read still drops it
          // data read raises flag
          nxt_r.rdy_n = 1'b1;
        end
      end
      ACS_RD:
      begin
        // Bit moves on the fall, host takes it on the rise
        if (sclk_fall && r_ff.cnt != 6'h00)
        begin
          nxt_r.dout = r_ff.sh[31];
          nxt_r.sh   = {r_ff.sh[30:0], 1'b0};
          nxt_r.cnt  = r_ff.cnt - 6'h01;
        end
        if (sclk_rise && r_ff.cnt == 6'h00)
        begin
          nxt_r.st  = ACS_CMD;
          nxt_r.cnt = ACS_BITS_CMD;
        end
      end
      default:
      begin
        nxt_r.st  = ACS_CMD;
        nxt_r.cnt = ACS_BITS_CMD;
      end
    endcase

    // Deselect aborts any frame
    // Count restarts, so no stale partial command
    if (r_ff.cs_s2)
    begin
      nxt_r.st  = ACS_CMD;
      nxt_r.cnt = ACS_BITS_CMD;
    end

    // Events come last so they win over frame updates in the same cycle
    if (result_valid)
    begin
      if (result_over)
        nxt_r.data = ACS_FS_POS;
      else if (result_under)
        nxt_r.data = ACS_FS_NEG;
      else
        nxt_r.data = result_data;
      nxt_r.range_f = result_over | result_under;
      nxt_r.chan = result_chan;
    end
    if (result_valid || cal_done)
      nxt_r.rdy_n = 1'b0;
    if (wr_crc_mismatch)
      nxt_r.crc_f = 1'b1;

    // reference taken on enable
    // Reference taken once, on the rising enable
    nxt_r.integ_en_d = integ_check_en;
    if (integ_check_en && !r_ff.integ_en_d)
      nxt_r.ref_sum = cfg_signature;
    else if (integ_check_en && cfg_signature != r_ff.ref_sum)
      nxt_r.integ_f = 1'b1;
    if (!integ_check_en)
      nxt_r.integ_f = 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_ff         <= '0;
      // Clock and select lines idle high, so no false edge after reset
      r_ff.sclk_s1 <= 1'b1;
      r_ff.sclk_s2 <= 1'b1;
      r_ff.sclk_s3 <= 1'b1;
      r_ff.cs_s1   <= 1'b1;
      r_ff.cs_s2   <= 1'b1;
      r_ff.st      <= ACS_CMD;
      r_ff.cnt     <= ACS_BITS_CMD;
      r_ff.sel     <= ACS_CMD_RESET;
      r_ff.rdy_n   <= ACS_STATUS_RESET[ACS_ST_RDY];
      r_ff.dout    <= ACS_STATUS_RESET[ACS_ST_RDY];
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign dout           = r_ff.dout;
  assign dout_oe        = r_ff.dout_oe;
  assign reg_sel        = r_ff.sel;
  assign reg_wr_strobe  = r_ff.wr_strobe;
  assign reg_wr_data    = r_ff.wr_data;
  assign filter_restart = r_ff.mode_wr;
  assign status_byte    = acs_pack_status(r_ff);
  assign data_word      = r_ff.data;

endmodule

/* acs_host_model.sv */
`timescale 1ns/1ps
module acs_host_model
(
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // ====
  // One framed access
  // command then whole payload
  task automatic frame(input logic [7:0] cmd, input logic [31:0] wr,
                       input int nb, output logic [31:0] rd);
    logic [39:0] tx;
    tx = {cmd, wr << (32 - nb)};
    rd = '0;
    // Quarter-ns offset keeps every pin edge off both clock edges
    repeat (50) @(negedge clk);
    #0.25;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < 8 + nb; i++)
    begin
      sclk = 1'b0;
      din  = tx[39 - i];
      #62.5;
      sclk = 1'b1;
      if (i >= 8)
        rd = {rd[30:0], dout};
      #62.5;
    end
    #100;
    cs_n = 1'b1;
    // Released line flips so a stale bit never looks valid
    din  = ~din;
  endtask
endmodule

/* acs_pkg.sv */
package acs_pkg;

  // ==========================================================
  // Command byte layout
  localparam int unsigned ACS_CMD_WEN_BIT = 7;
  localparam int unsigned ACS_CMD_RD_BIT  = 6;
  localparam logic [5:0]  ACS_CMD_RESET   = 6'h00;

  // ==========================================================
  // Target register select codes
  localparam logic [5:0] ACS_SEL_STATUS  = 6'h00;
  localparam logic [5:0] ACS_SEL_MODE    = 6'h01;
  localparam logic [5:0] ACS_SEL_IFMODE  = 6'h02;
  localparam logic [5:0] ACS_SEL_CSUM    = 6'h03;
  localparam logic [5:0] ACS_SEL_DATA    = 6'h04;
  localparam logic [5:0] ACS_SEL_GPIO    = 6'h06;
  localparam logic [5:0] ACS_SEL_ID      = 6'h07;
  localparam logic [3:0] ACS_GRP_CHAN    = 4'h4;
  localparam logic [3:0] ACS_GRP_SETUP   = 4'h8;
  localparam logic [3:0] ACS_GRP_FILT    = 4'ha;
  localparam logic [3:0] ACS_GRP_OFFS    = 4'hc;
  localparam logic [3:0] ACS_GRP_GAIN    = 4'he;

  // ==========================================================
  // Transfer lengths in bits
  localparam logic [5:0] ACS_BITS_NONE = 6'h00;
  localparam logic [5:0] ACS_BITS_B1   = 6'h08;
  localparam logic [5:0] ACS_BITS_B2   = 6'h10;
  localparam logic [5:0] ACS_BITS_B3   = 6'h18;
  localparam logic [5:0] ACS_BITS_CMD  = 6'h08;

  // ==========================================================
  // Status byte layout and reset
  localparam int unsigned ACS_ST_RDY   = 7;
  localparam int unsigned ACS_ST_RANGE = 6;
  localparam int unsigned ACS_ST_CRC   = 5;
  localparam int unsigned ACS_ST_INTEG = 4;
  localparam logic [7:0]  ACS_STATUS_RESET = 8'h80;
  localparam logic [1:0]  ACS_ST_RSVD      = 2'h0;

  // ==========================================================
  // Result clamp levels, offset binary coding
  localparam logic [23:0] ACS_FS_POS = 24'hffffff;
  localparam logic [23:0] ACS_FS_NEG = 24'h000000;

  typedef enum logic [1:0]
  {
    ACS_CMD  = 2'b00,
    ACS_WR   = 2'b01,
    ACS_LD   = 2'b10,
    ACS_RD   = 2'b11
  } acs_state_t;

endpackage

/* acs_properties.sv */
`timescale 1ns/1ps
module acs_properties
  import acs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        dout_oe,
  input wire logic        result_valid,
  input wire logic [1:0]  result_chan,
  input wire logic        result_over,
  input wire logic        result_under,
  input wire logic        wr_crc_mismatch,
  input wire logic        integ_check_en,
  input wire logic        reg_wr_strobe,
  input wire logic [5:0]  reg_sel,
  input wire logic        filter_restart,
  input wire logic [7:0]  status_byte,
  input wire logic [23:0] data_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ====
  // Result events
  chk_chan_held: assert property (
    result_valid |=> status_byte[1:0] == $past(result_chan))
    else $error("channel field wrong");
  chk_rdy_drop: assert property (
    result_valid |=> !status_byte[ACS_ST_RDY])
    else $error("ready flag did not drop");
  chk_range_set: assert property (
    result_valid && (result_over || result_under)
    |=> status_byte[ACS_ST_RANGE])
    else $error("range fault not set");
  chk_range_clr: assert property (
    result_valid && !result_over && !result_under
    |=> !status_byte[ACS_ST_RANGE])
    else $error("range fault not cleared");
  chk_clamp_pos: assert property (
    result_valid && result_over |=> data_word == ACS_FS_POS)
    else $error("overrange not clamped");

  // ====
  // Fault flags and reserved bits
  chk_crc_set: assert property (
    wr_crc_mismatch |=> status_byte[ACS_ST_CRC])
    else $error("write check fault not set");
  chk_integ_clear: assert property (
    !integ_check_en [*2] |=> !status_byte[ACS_ST_INTEG])
    else $error("integrity fault held while disabled");
  chk_rsvd_zero: assert property (
    status_byte[3:2] == ACS_ST_RSVD)
    else $error("reserved status bits set");

  // ====
  // Register writes
  chk_strobe_pulse: assert property (
    reg_wr_strobe |-> reg_sel != ACS_SEL_STATUS ##1 !reg_wr_strobe)
    else $error("bad write strobe");
  chk_mode_restart: assert property (
    filter_restart |-> reg_wr_strobe && reg_sel == ACS_SEL_MODE
    ##[0:2] status_byte[ACS_ST_RDY])
    else $error("mode write did not restart");

  chk_oe_select: assert property (
    $stable(cs_n) [*4] |-> dout_oe == !cs_n)
    else $error("output enable does not follow select");

  cover property (filter_restart);
  cover property (result_valid && result_over);
  cover property (wr_crc_mismatch ##1 status_byte[ACS_ST_CRC]);
endmodule

bind acs_command_status acs_properties u_props (.clk(clk), .rst(rst),
  .cs_n(cs_n), .dout_oe(dout_oe),
  .result_valid(result_valid), .result_chan(result_chan),
  .result_over(result_over), .result_under(result_under),
  .wr_crc_mismatch(wr_crc_mismatch), .integ_check_en(integ_check_en),
  .reg_wr_strobe(reg_wr_strobe), .reg_sel(reg_sel),
  .filter_restart(filter_restart), .status_byte(status_byte),
  .data_word(data_word));

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top import acs_pkg::*;;
  logic        clk, rst, sclk, cs_n, din, dout, dout_oe, reg_wr_strobe;
  logic        filter_restart, result_valid, result_over, result_under;
  logic        cal_done, wr_crc_mismatch, append_status_en, integ_check_en;
  logic [5:0]  reg_sel;
  logic [1:0]  result_chan;
  logic [7:0]  status_byte;
  logic [23:0] reg_wr_data, reg_rd_data, result_data, cfg_signature;
  logic [23:0] data_word, e;
  logic [31:0] rd, w;
  logic [29:0] exp_wr[$];
  logic [5:0]  sels[13] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h07, 6'h10,
                            6'h13, 6'h20, 6'h23, 6'h28, 6'h2b, 6'h30,
                            6'h3b};
  int          n_fail, checks_done, seed, nb;

  assign reg_rd_data = {4{reg_sel}};
  acs_command_status u_dut (.*);
  acs_host_model u_host (.*);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ====
  // Checking
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask

  // Strobe looked at mid-cycle, where it stands settled
  always @(negedge clk)
    if (reg_wr_strobe === 1'b1)
      cmp("write", exp_wr.size() ? exp_wr.pop_front() : 'x,
          {reg_sel, reg_wr_data});

  task automatic pulse(input logic [2:0] m);
    @(negedge clk);
    {cal_done, wr_crc_mismatch, result_valid} = m;
    @(negedge clk);
    {cal_done, wr_crc_mismatch, result_valid} = 3'h0;
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #300us;
    n_fail++;
    give_verdict;
  end

  // ====
  // Tests
  initial
  begin
    seed = 17;
    rst = 1'b1;
    {result_valid, result_over, result_under, cal_done} = '0;
    {wr_crc_mismatch, append_status_en, integ_check_en} = '0;
    {result_data, result_chan, cfg_signature} = '0;
    repeat (2) @(negedge clk);
    cmp("status reset", 8'h80, status_byte);
    cmp("oe idle", 0, dout_oe);
    rst = 1'b0;
    u_host.frame(8'h40, 0, 8, rd);
    cmp("status read", 8'h80, rd);
    pulse(3'h2);
    u_host.frame(8'h40, 0, 8, rd);
    cmp("crc set", 1, rd[ACS_ST_CRC]);
    u_host.frame(8'h40, 0, 8, rd);
    cmp("crc cleared", 0, rd[ACS_ST_CRC]);
    $display("test status done");
    foreach (sels[k])
    begin
      nb = sels[k][5:4] == 2'b11 || sels[k] == ACS_SEL_CSUM ? 24 : 16;
      w = $random(seed) & ((1 << nb) - 1);
      exp_wr.push_back({sels[k], w[23:0]});
      u_host.frame({2'b00, sels[k]}, w, nb, rd);
      u_host.frame({2'b01, sels[k]}, 0, nb, rd);
      cmp("read back", {4{sels[k]}} & ((1 << nb) - 1), rd);
    end
    // Refused byte then a real write in the same frame
    exp_wr.push_back({6'h02, 24'h001234});
    u_host.frame(8'h82, 32'h021234, 24, rd);
    // Unmapped selector is refused the same way
    exp_wr.push_back({6'h02, 24'h00abcd});
    u_host.frame(8'h05, 32'h02abcd, 24, rd);
    u_host.frame(8'h00, 8'h5a, 8, rd);
    $display("test registers done");
    append_status_en = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      result_data = 24'($random(seed));
      {result_chan, result_over, result_under} = {j[1:0], j == 1, j == 2};
      e = j == 1 ? ACS_FS_POS : j == 2 ? ACS_FS_NEG : result_data;
      pulse(3'h1);
      exp_wr.push_back({6'h02, 24'h0});
      u_host.frame(8'h02, 0, 16, rd);
      cmp("ready pin", 0, rd);
      u_host.frame(8'h44, 0, 32, rd);
      cmp("data", e, rd[31:8]);
      cmp("appended", {j == 1 || j == 2, 4'h0, j[1:0]}, rd[6:0]);
      cmp("ready after read", 1, status_byte[ACS_ST_RDY]);
    end
    append_status_en = 1'b0;
    pulse(3'h4);
    cmp("cal ready", 0, status_byte[ACS_ST_RDY]);
    exp_wr.push_back({ACS_SEL_MODE, 24'h008000});
    u_host.frame(8'h01, 32'h8000, 16, rd);
    cmp("mode ready", 1, status_byte[ACS_ST_RDY]);
    $display("test results done");
    cfg_signature = 24'h123456;
    integ_check_en = 1'b1;
    repeat (4) @(negedge clk);
    cmp("integ quiet", 0, status_byte[ACS_ST_INTEG]);
    cfg_signature = 24'h123457;
    repeat (4) @(negedge clk);
    cmp("integ set", 1, status_byte[ACS_ST_INTEG]);
    integ_check_en = 1'b0;
    repeat (4) @(negedge clk);
    cmp("integ clear", 0, status_byte[ACS_ST_INTEG]);
    cmp("writes left", 0, exp_wr.size());
    $display("test integrity done");
    give_verdict;
  end
endmodule
